// ==== design/cfg_mirror.sv ====
// System clock copy of the serially written configuration registers
`timescale 1ns/100ps
module cfg_mirror (
  // System clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Write event from the serial clock domain
  input  wire logic         wrToggle,
  input  wire logic [4:0]   wrAddr,
  input  wire logic [7:0]   wrData,
  // Mirrored register contents, register n in bits 8n+7 down to 8n
  output logic      [255:0] cfgRegs
);

  logic togMeta_q;
  logic togSync_q;
  logic togSeen_q;
  logic wrEvent;

  // Two-stage synchroniser on the toggle; only the second stage feeds logic
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      togMeta_q <= 1'b0;
      togSync_q <= 1'b0;
      togSeen_q <= 1'b0;
    end else begin
      togMeta_q <= wrToggle;
      togSync_q <= togMeta_q;
      togSeen_q <= togSync_q;
    end
  end

  assign wrEvent = togSync_q ^ togSeen_q;

  // Address and data stay put for at least eight serial clocks after a toggle,
  // far longer than the three system clocks the crossing takes
  genvar gi;
  generate
    for (gi = 0; gi < serial_config_port_pkg::NUM_REGS; gi++) begin : gMirror
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          cfgRegs[gi*8 +: 8] <= (gi == 0) ? serial_config_port_pkg::SERIAL_PORT_CONFIG_RESET
                                          : serial_config_port_pkg::OTHER_REG_RESET;
        end else if (wrEvent && (wrAddr == 5'(gi))) begin
          cfgRegs[gi*8 +: 8] <= wrData;
        end
      end
    end
  endgenerate

endmodule

// ==== design/serial_config_port.sv ====
// Serial configuration port: instruction decode, register file and pin drive
`timescale 1ns/100ps

module serial_config_port (
  // System clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Serial link from the host
  input  wire logic         serialClk,
  input  wire logic         cycleSelectN,
  input  wire logic         serialDataIn,
  // Bidirectional data pin, driven side
  output logic              serialDataIoOut,
  output logic              serialDataIoOe,
  // Dedicated serial output pin
  output logic              serialDataOut,
  output logic              serialDataOutOe,
  // Strap pins
  input  wire logic         portDisablePin,
  input  wire logic         singleRatePin,
  // System side view
  output logic      [255:0] cfgRegs,
  output logic              portDisabled,
  output logic              singleRateMode
);

  // Register file, serial clock domain
  logic [7:0] regs_q [serial_config_port_pkg::NUM_REGS];

  // Controller state
  serial_config_port_pkg::phase_t phase_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic       isRead_q;
  logic [1:0] bytesLeft_q;
  logic [4:0] addr_q;
  logic [7:0] rdByte_q;

  // Crossing towards the system clock
  logic       wrToggle_q;
  logic [4:0] wrAddr_q;
  logic [7:0] wrData_q;

  // Strap synchronisers on the system clock
  logic disMeta_q;
  logic disSync_q;
  logic srMeta_q;
  logic srSync_q;

  // Decoded controller terms
  logic       serRstN;
  logic       lsbFirst;
  logic       threeWire;
  logic [7:0] shiftNext;
  logic       byteDone;
  logic       instrDone;
  logic       dataDone;
  logic       wrCommit;
  logic       lastByte;
  logic [4:0] stepAddr;
  logic       readDrive;
  logic       readBit;

  // Next address of a multibyte transfer; wraps inside the 32-entry map
  function automatic logic [4:0] nextAddress(input logic [4:0] a, input logic lsbOrder);
    logic [4:0] n;
    n = lsbOrder ? 5'(a + 5'h01) : 5'(a - 5'h01);
    return n;
  endfunction

  // Frame reset: select high, port disabled or device reset all clear the
  // controller; the strap acts as a reset because the serial clock may stand still
  assign serRstN = resetn & ~cycleSelectN & ~portDisablePin;

  // Mode bits are read straight from the stored register, so a new value acts
  // from the very next serial edge, even in the middle of a multibyte frame
  assign lsbFirst  = regs_q[serial_config_port_pkg::SERIAL_PORT_CONFIG_ADDR]
                       [serial_config_port_pkg::CFG_LSB_FIRST_BIT];
  assign threeWire = regs_q[serial_config_port_pkg::SERIAL_PORT_CONFIG_ADDR]
                       [serial_config_port_pkg::CFG_THREE_WIRE_BIT];

  // Shift in by the active bit order; the instruction byte obeys it too
  assign shiftNext = lsbFirst ? {serialDataIn, shift_q[7:1]}
                              : {shift_q[6:0], serialDataIn};

  // Byte boundaries and per-byte decisions
  assign byteDone  = (bitCnt_q == serial_config_port_pkg::BIT_CNT_LAST);
  assign instrDone = (phase_q == serial_config_port_pkg::PH_INSTR) && byteDone;
  assign dataDone  = (phase_q == serial_config_port_pkg::PH_DATA) && byteDone;
  assign wrCommit  = dataDone && !isRead_q;
  assign lastByte  = (bytesLeft_q == 2'h0);
  assign stepAddr  = nextAddress(addr_q, lsbFirst);

  // Bit position in the read byte for the current count
  assign readBit = lsbFirst ? rdByte_q[bitCnt_q]
                            : rdByte_q[3'(serial_config_port_pkg::BIT_CNT_LAST - bitCnt_q)];
  assign readDrive = (phase_q == serial_config_port_pkg::PH_DATA) && isRead_q;

  // Bit counter: runs over every byte of the frame, wrapping at eight
  always_ff @(posedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      bitCnt_q <= serial_config_port_pkg::BIT_CNT_RESET;
    end else begin
      bitCnt_q <= 3'(bitCnt_q + 3'h1);
    end
  end

  // Input shift register, sampled on rising edges only
  always_ff @(posedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= shiftNext;
    end
  end

  // Frame phase; after the last byte further edges are ignored until select rises
  always_ff @(posedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      phase_q <= serial_config_port_pkg::PH_INSTR;
    end else begin
      unique case (phase_q)
        serial_config_port_pkg::PH_INSTR: begin
          if (instrDone) begin
            phase_q <= serial_config_port_pkg::PH_DATA;
          end
        end
        serial_config_port_pkg::PH_DATA: begin
          if (dataDone && lastByte) begin
            phase_q <= serial_config_port_pkg::PH_DONE;
          end
        end
        serial_config_port_pkg::PH_DONE: begin
          phase_q <= serial_config_port_pkg::PH_DONE;
        end
        default: begin
          phase_q <= serial_config_port_pkg::PH_INSTR;
        end
      endcase
    end
  end

  // Instruction fields: direction and remaining byte count
  always_ff @(posedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      isRead_q    <= 1'b0;
      bytesLeft_q <= 2'h0;
    end else if (instrDone) begin
      isRead_q    <= shiftNext[serial_config_port_pkg::INSTR_READ_BIT];
      bytesLeft_q <= shiftNext[serial_config_port_pkg::INSTR_COUNT_HI:
                               serial_config_port_pkg::INSTR_COUNT_LO];
    end else if (dataDone && !lastByte) begin
      bytesLeft_q <= 2'(bytesLeft_q - 2'h1);
    end
  end

  // Working address: loaded from the instruction, stepped after each byte
  always_ff @(posedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      addr_q <= 5'h00;
    end else if (instrDone) begin
      addr_q <= shiftNext[serial_config_port_pkg::INSTR_ADDR_HI:0];
    end else if (dataDone) begin
      addr_q <= stepAddr;
    end
  end

  // Read byte: fetched on the eighth rising edge so its first bit is ready
  // for the falling edge that follows
  always_ff @(posedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      rdByte_q <= 8'h00;
    end else if (instrDone && shiftNext[serial_config_port_pkg::INSTR_READ_BIT]) begin
      rdByte_q <= regs_q[shiftNext[serial_config_port_pkg::INSTR_ADDR_HI:0]];
    end else if (dataDone && isRead_q && !lastByte) begin
      rdByte_q <= regs_q[stepAddr];
    end
  end

  // Register file: survives select and disable, cleared only by device reset;
  // a byte cut short by select rising is never written
  genvar gi;
  generate
    for (gi = 0; gi < serial_config_port_pkg::NUM_REGS; gi++) begin : gRegs
      always_ff @(posedge serialClk or negedge resetn) begin
        if (!resetn) begin
          regs_q[gi] <= (gi == 0) ? serial_config_port_pkg::SERIAL_PORT_CONFIG_RESET
                                  : serial_config_port_pkg::OTHER_REG_RESET;
        end else if (wrCommit && (addr_q == 5'(gi)) && !cycleSelectN && !portDisablePin) begin
          regs_q[gi] <= shiftNext;
        end
      end
    end
  endgenerate

  // Write event towards the system clock: toggle plus held address and data
  always_ff @(posedge serialClk or negedge resetn) begin
    if (!resetn) begin
      wrToggle_q <= 1'b0;
      wrAddr_q   <= 5'h00;
      wrData_q   <= 8'h00;
    end else if (wrCommit && !cycleSelectN && !portDisablePin) begin
      wrToggle_q <= ~wrToggle_q;
      wrAddr_q   <= addr_q;
      wrData_q   <= shiftNext;
    end
  end

  // Pin drive on falling edges; select rising clears it at once
  always_ff @(negedge serialClk or negedge serRstN) begin
    if (!serRstN) begin
      serialDataIoOut <= 1'b0;
      serialDataIoOe  <= 1'b0;
      serialDataOut   <= 1'b0;
      serialDataOutOe <= 1'b0;
    end else begin
      serialDataIoOut <= readBit;
      serialDataIoOe  <= readDrive && threeWire;
      serialDataOut   <= readBit;
      serialDataOutOe <= readDrive && !threeWire;
    end
  end

  // Strap pins come from outside: two flops before use
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      disMeta_q <= 1'b0;
      disSync_q <= 1'b0;
      srMeta_q  <= 1'b0;
      srSync_q  <= 1'b0;
    end else begin
      disMeta_q <= portDisablePin;
      disSync_q <= disMeta_q;
      srMeta_q  <= singleRatePin;
      srSync_q  <= srMeta_q;
    end
  end

  // Single rate is honoured only while the port is disabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portDisabled   <= 1'b0;
      singleRateMode <= 1'b0;
    end else begin
      portDisabled   <= disSync_q;
      singleRateMode <= disSync_q && srSync_q;
    end
  end

  // System clock copy of the register file
  cfg_mirror uMirror (
    .mclk     (mclk),
    .resetn   (resetn),
    .wrToggle (wrToggle_q),
    .wrAddr   (wrAddr_q),
    .wrData   (wrData_q),
    .cfgRegs  (cfgRegs)
  );

endmodule

// ==== design/serial_config_port_pkg.sv ====
// Constants and types shared by the serial configuration port files
package serial_config_port_pkg;

  // Register file geometry
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_REGS = 32;

  // Register offsets
  localparam logic [4:0] SERIAL_PORT_CONFIG_ADDR = 5'h00;

  // Values after reset
  localparam logic [7:0] SERIAL_PORT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] OTHER_REG_RESET          = 8'h00;

  // Field positions in the serial port configuration register
  localparam int unsigned CFG_LSB_FIRST_BIT  = 6;
  localparam int unsigned CFG_THREE_WIRE_BIT = 7;

  // Field positions in the instruction byte
  localparam int unsigned INSTR_READ_BIT   = 7;
  localparam int unsigned INSTR_COUNT_HI   = 6;
  localparam int unsigned INSTR_COUNT_LO   = 5;
  localparam int unsigned INSTR_ADDR_HI    = 4;

  // Bit counter values
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST  = 3'h7;

  // Serial clock ceiling and the system clock rate, in Hz
  localparam int unsigned SERIAL_CLK_MAX_HZ = 15_000_000;
  localparam int unsigned MCLK_HZ           = 100_000_000;

  // Frame phase of the serial controller
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_DATA,
    PH_DONE
  } phase_t;

endpackage

// ==== sim/serial_config_port_properties.sv ====
// Checker for the serial configuration port pins and strap outputs
`timescale 1ns/100ps
module serial_config_port_properties (
  // Clocks and resets
  input wire logic         mclk,
  input wire logic         resetn,
  input wire logic         serialClk,
  input wire logic         cycleSelectN,
  // Pin drive
  input wire logic         serialDataIoOe,
  input wire logic         serialDataOutOe,
  // Straps and mirror
  input wire logic         portDisablePin,
  input wire logic         portDisabled,
  input wire logic         singleRateMode,
  input wire logic [255:0] cfgRegs
);
  logic [5:0] riseCnt;
  wire        anyOe = serialDataIoOe | serialDataOutOe;
  // Rising edges in this frame; saturates so long frames cannot wrap
  always_ff @(posedge serialClk or posedge cycleSelectN) begin
    if (cycleSelectN) riseCnt <= 6'h00;
    else if (riseCnt != 6'h3F) riseCnt <= riseCnt + 6'h01;
  end
  // Strap output follows the pin after two sync flops and one output flop
  sequence syncWait;
    !portDisabled ##1 !portDisabled ##1 !portDisabled ##1 portDisabled;
  endsequence
  sdo_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    cycleSelectN |-> !serialDataOutOe) else $error("output pin driven while idle");
  io_release_a: assert property (@(posedge mclk) disable iff (!resetn)
    cycleSelectN |-> !serialDataIoOe) else $error("data pin driven while idle");
  oe_exclusive_a: assert property (@(posedge mclk) disable iff (!resetn)
    !(serialDataIoOe && serialDataOutOe)) else $error("both pins driven");
  three_wire_sdo_a: assert property (@(posedge mclk) disable iff (!resetn)
    cfgRegs[7] |-> !serialDataOutOe) else $error("output pin driven in three-wire mode");
  disable_sync_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(portDisablePin) |-> syncWait) else $error("disable strap latency wrong");
  rate_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    !portDisablePin [*5] |-> !singleRateMode) else $error("single rate while port enabled");
  no_early_drive_a: assert property (@(negedge serialClk)
    disable iff (!resetn || cycleSelectN)
    riseCnt <= 6'h08 |-> !anyOe) else $error("pin driven during instruction");
  first_bit_a: assert property (@(negedge serialClk)
    disable iff (!resetn || cycleSelectN)
    $rose(anyOe) |-> riseCnt == 6'h09) else $error("read drive not after eighth rise");
endmodule

// ==== sim/serial_config_port_tb.sv ====
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
module serial_config_port_tb;
  logic          mclk = 1'b0;
  logic          resetn = 1'b0;
  logic          pdPin = 1'b0;
  logic          srPin = 1'b0;
  logic          sclk, csN, sdi, ioOut, ioOe, sdoOut, sdoOe, portDisabled, singleRateMode;
  logic [255:0]  cfgRegs;
  logic [31:0]   r;
  int            badCount = 0;
  int            checked = 0;
  wire           sdioWire = ioOe ? ioOut : sdi;
  wire           sdoWire = sdoOe ? sdoOut : 1'bz;
  always #5 mclk = ~mclk;
  serial_host_model host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdio(sdioWire), .serial_data_out(sdoWire));
  serial_config_port uut (
    .mclk(mclk), .resetn(resetn), .serialClk(sclk), .cycleSelectN(csN),
    .serialDataIn(sdioWire), .serialDataIoOut(ioOut), .serialDataIoOe(ioOe),
    .serialDataOut(sdoOut), .serialDataOutOe(sdoOe), .portDisablePin(pdPin),
    .singleRatePin(srPin), .cfgRegs(cfgRegs), .portDisabled(portDisabled),
    .singleRateMode(singleRateMode));
  // Ends the run with the verdict
  task finishTest;
    if (badCount == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h got %h", name, exp, got);
    end
  endtask
  // Write frame sized from the count field, then let the mirror catch up
  task wr(input logic [7:0] ins, input logic [31:0] d);
    host.frame(ins, d, 8 * (ins[6:5] + 2), r);
    repeat (6) @(posedge mclk);
  endtask
  task rdf(input logic [7:0] ins);
    host.frame(ins, 32'h0, 8 * (ins[6:5] + 2), r);
  endtask
  // Watchdog sized well beyond the thirteen frames of the run
  initial begin
    #100000;
    badCount++;
    finishTest;
  end
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check("reset", 32'h1, {31'h0, cfgRegs === 256'h0});
    wr(8'h05, 32'hA5);
    check("reg05", 32'hA5, {24'h0, cfgRegs[47:40]});
    rdf(8'h85);
    check("rd05", 32'hA5, r);
    wr(8'h6A, 32'h44332211);
    check("reg07_0A", 32'h11223344, cfgRegs[87:56]);
    rdf(8'hEA);
    check("rd07_0A", 32'h44332211, r);
    host.frame(8'h34, 32'h6655, 20, r);
    repeat (6) @(posedge mclk);
    check("abort", 32'h5500, {16'h0, cfgRegs[167:152]});
    wr(8'h00, 32'h40);
    host.lsbFirst = 1'b1;
    wr(8'h58, 32'hC3B2A1);
    check("reg18_1A", 32'hC3B2A1, {8'h0, cfgRegs[215:192]});
    rdf(8'hD8);
    check("rd18_1A", 32'hC3B2A1, r);
    wr(8'h00, 32'hC0);
    host.threeWire = 1'b1;
    rdf(8'h98);
    check("rd3w", 32'hA1, r);
    wr(8'h00, 32'h00);
    host.lsbFirst = 1'b0;
    host.threeWire = 1'b0;
    rdf(8'h80);
    check("rdcfg", 32'h0, r);
    pdPin <= 1'b1;
    srPin <= 1'b1;
    repeat (5) @(posedge mclk);
    check("disabled", 32'h3, {30'h0, portDisabled, singleRateMode});
    wr(8'h05, 32'h3C);
    check("ignored", 32'hA5, {24'h0, cfgRegs[47:40]});
    pdPin <= 1'b0;
    repeat (5) @(posedge mclk);
    check("enabled", 32'h0, {30'h0, portDisabled, singleRateMode});
    finishTest;
  end
endmodule
bind serial_config_port serial_config_port_properties chk (
  .mclk(mclk), .resetn(resetn), .serialClk(serialClk), .cycleSelectN(cycleSelectN),
  .serialDataIoOe(serialDataIoOe), .serialDataOutOe(serialDataOutOe),
  .portDisablePin(portDisablePin), .portDisabled(portDisabled),
  .singleRateMode(singleRateMode), .cfgRegs(cfgRegs));

// ==== sim/serial_host_model.sv ====
// Behavioural serial host that frames cycles and shifts bits
`timescale 1ns/100ps
module serial_host_model (
  // Pins toward the port
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  // Resolved data pins
  input  wire logic sdio,
  input  wire logic serial_data_out
);
  logic lsbFirst;
  logic threeWire;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    lsbFirst = 1'b0;
    threeWire = 1'b0;
  end
  // One frame; rises below the full count cuts the frame short
  task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input int rises,
                       output logic [31:0] rd);
    logic [39:0] all;
    int          i;
    int          k;
    all = {wd, ins};
    rd = 32'h0;
    #7 csN = 1'b0;
    #20;
    for (i = 0; i < rises; i++) begin
      k = lsbFirst ? i % 8 : 7 - i % 8;
      // Released line toggles so a stale value never reads as data
      sdi = (ins[7] && i >= 8) ? ~sdi : all[(i / 8) * 8 + k];
      #15 sclk = 1'b1; // Link clock half period
      if (i >= 8) rd[(i / 8 - 1) * 8 + k] = threeWire ? sdio : serial_data_out;
      #15 sclk = 1'b0;
    end
    #20 csN = 1'b1;
    #40;
  endtask
endmodule
